// File: hw/vsg_pkg.sv
// Shared constants and helpers for the video sync generator control block
package vsg_pkg;

	// ------------------------------------------------------------------
	// Widths and register map
	// ------------------------------------------------------------------
	localparam int DW       = 12;
	localparam int AW       = 5;
	localparam int CW       = 13;
	localparam int NUM_REGS = 5;
	localparam int SYNC_W   = 11;

	localparam logic [AW-1:0] ADDR_MODE     = 5'h00;
	localparam logic [AW-1:0] ADDR_FRONT    = 5'h01;
	localparam logic [AW-1:0] ADDR_SYNC_END = 5'h02;
	localparam logic [AW-1:0] ADDR_BLANK_W  = 5'h03;
	localparam logic [AW-1:0] ADDR_LINE_LEN = 5'h04;

	// ------------------------------------------------------------------
	// Mode and output control field positions
	// ------------------------------------------------------------------
	localparam int BIT_BLANK_SEL = 0;
	localparam int BIT_SYNC_SEL  = 1;
	localparam int BIT_SPARE_SEL = 2;
	localparam int BIT_MODE_LO   = 3;
	localparam int BIT_MODE_HI   = 4;
	localparam int BIT_POL_BLANK = 5;
	localparam int BIT_POL_SYNC  = 6;
	localparam int BIT_POL_LINE  = 7;
	localparam int BIT_POL_LSYNC = 8;
	localparam int BIT_EQ_OFF    = 9;
	localparam int BIT_CLK_ON    = 10;
	localparam int BIT_TEST      = 11;

	localparam logic [1:0] CODE_INTERLACED = 2'h0;
	localparam logic [1:0] CODE_NI_DOUBLE  = 2'h1;
	localparam logic [1:0] CODE_ILLEGAL    = 2'h2;

	typedef enum logic [1:0] {MD_INTERLACED, MD_NI_DOUBLE, MD_NI_SINGLE} mode_t;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [DW-1:0] STATUS_RESET_BASE = 12'h000;
	localparam logic [DW-1:0] STATUS_RESET_CLK  = 12'h400;
	localparam logic [DW-1:0] FRONT_RESET       = 12'h010;
	localparam logic [DW-1:0] SYNC_END_RESET    = 12'h050;
	localparam logic [DW-1:0] BLANK_RESET       = 12'h0A0;
	localparam logic [DW-1:0] LINE_RESET        = 12'h320;
	localparam logic [CW-1:0] VCNT_RESET        = 13'h0001;
	localparam logic          OUT_RESET         = 1'b1;

	function automatic logic [NUM_REGS-1:0][DW-1:0] reset_regs(
		input logic clk_on);
		reset_regs = {LINE_RESET, BLANK_RESET, SYNC_END_RESET, FRONT_RESET,
			clk_on ? STATUS_RESET_CLK : STATUS_RESET_BASE};
	endfunction

	function automatic logic in_window(input logic [CW-1:0] cnt,
		input logic [CW-1:0] start, input logic [CW-1:0] stop);
		in_window = (cnt >= start) && (cnt < stop);
	endfunction

	function automatic logic apply_pol(input logic act, input logic pol);
		apply_pol = act ~^ pol;
	endfunction

endpackage

// File: hw/vsg_load_port.sv
// Parallel load port: strobe synchroniser, address counter, shadow registers
`timescale 1ns/100ps
`default_nettype none
module vsg_load_port #(
	parameter bit CLOCK_ON_AT_CLEAR = 1'b0
) (
	// Clock and resets
	input  wire logic                     sys_clk,
	input  wire logic                     reset_n,
	input  wire logic                     async_init,
	// Load port pins
	input  wire logic [7:0]               data_in,
	input  wire logic                     addr_data_sel,
	input  wire logic                     byte_half_select,
	input  wire logic                     load_strobe,
	// Shadow register contents
	output logic [vsg_pkg::NUM_REGS-1:0][vsg_pkg::DW-1:0] shadow_regs
);

	typedef struct packed {
		logic [vsg_pkg::SYNC_W-1:0]                  sync1;
		logic [vsg_pkg::SYNC_W-1:0]                  sync2;
		logic                                        load_prev;
		logic                                        ad_q;
		logic                                        half_q;
		logic                                        auto_inc;
		logic [vsg_pkg::AW-1:0]                      addr;
		logic [vsg_pkg::NUM_REGS-1:0][vsg_pkg::DW-1:0] regs;
	} port_t;

	port_t st_r;
	port_t st_nxt;
	logic  fall;
	logic  rise;

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	// The strobe and its qualifiers pass the same two stages, so they stay
	// aligned with one another whatever the strobe's phase to the clock.
	always_comb begin
		st_nxt = st_r;
		st_nxt.sync1 = {load_strobe, addr_data_sel, byte_half_select, data_in};
		st_nxt.sync2 = st_r.sync1;
		st_nxt.load_prev = st_r.sync2[10];
		fall = st_r.load_prev & ~st_r.sync2[10];
		rise = ~st_r.load_prev & st_r.sync2[10];
		if (fall) begin
			st_nxt.ad_q = st_r.sync2[9];
			st_nxt.half_q = st_r.sync2[8];
		end
		if (rise) begin
			if (!st_r.ad_q) begin
				st_nxt.addr = st_r.sync2[vsg_pkg::AW-1:0];
				st_nxt.auto_inc = st_r.half_q;
			end else begin
				if (st_r.addr < vsg_pkg::AW'(vsg_pkg::NUM_REGS)) begin
					if (st_r.half_q)
						st_nxt.regs[st_r.addr][11:8] = st_r.sync2[3:0];
					else
						st_nxt.regs[st_r.addr][7:0] = st_r.sync2[7:0];
				end
				if (st_r.auto_inc && st_r.half_q)
					st_nxt.addr = st_r.addr + 5'h01;
			end
		end
		if (!reset_n) begin
			st_nxt = '0;
			st_nxt.regs = vsg_pkg::reset_regs(CLOCK_ON_AT_CLEAR);
			// Strobe stages rest at the idle high level: no false edge
			st_nxt.sync1[10] = 1'b1;
			st_nxt.sync2[10] = 1'b1;
			st_nxt.load_prev = 1'b1;
		end
	end

	always_ff @(negedge sys_clk or posedge async_init) begin
		if (async_init) begin
			st_r <= '0;
			st_r.regs <= vsg_pkg::reset_regs(CLOCK_ON_AT_CLEAR);
			st_r.sync1[10] <= 1'b1;
			st_r.sync2[10] <= 1'b1;
			st_r.load_prev <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign shadow_regs = st_r.regs;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(negedge sys_clk); endclocking
	default disable iff (async_init || !reset_n);

	property p_addr_load;
		(rise && !st_r.ad_q) |=> (st_r.addr == $past(st_r.sync2[4:0]));
	endproperty
	a_addr_load: assert property (p_addr_load)
		else $error("address byte not loaded");

	property p_auto_step;
		(rise && st_r.ad_q && st_r.half_q && st_r.auto_inc)
			|=> (st_r.addr == $past(st_r.addr) + 5'h01);
	endproperty
	a_auto_step: assert property (p_auto_step)
		else $error("auto-load address did not advance");

	c_auto_write: cover property (rise && st_r.ad_q && st_r.auto_inc);

endmodule // vsg_load_port
`default_nettype wire

// File: hw/vsg_eq_shaper.sv
// Equalization and serration pulse shaping within one line
`timescale 1ns/100ps
`default_nettype none
module vsg_eq_shaper (
	// Line position and timing
	input  wire logic [vsg_pkg::DW-1:0] hcnt,
	input  wire logic [vsg_pkg::DW-1:0] line_len,
	input  wire logic [vsg_pkg::DW-1:0] front,
	input  wire logic [vsg_pkg::DW-1:0] eq_end,
	input  wire logic [vsg_pkg::DW-1:0] serr_end,
	input  wire logic                   double_rate,
	// Shaped pulses
	output logic                        eq_active,
	output logic                        serr_active
);

	logic [vsg_pkg::DW-1:0] half;
	logic [vsg_pkg::DW-1:0] hpos;

	// Double rate folds the line in two, hence the even line length.
	always_comb begin
		half = line_len >> 1;
		hpos = (double_rate && hcnt > half) ? hcnt - half : hcnt;
		eq_active = vsg_pkg::in_window({1'b0, hpos}, {1'b0, front},
			{1'b0, eq_end});
		serr_active = vsg_pkg::in_window({1'b0, hpos}, {1'b0, front},
			{1'b0, serr_end});
	end

endmodule // vsg_eq_shaper
`default_nettype wire

// File: hw/vsg_sync_gen.sv
// Video sync generator: load port, line and frame timing, output selection
// Operation
// - Load qualifier low means address byte, high means data byte.
// - Half qualifier low writes low eight bits, high writes upper nibble.
// - Address cycle with half qualifier high starts auto-load addressing.
// - Strobe rising edge writes the byte to address or data half.
// - Strobe independent of pixel clock; outputs change on falling edge.
// - Clear high asynchronously restores register defaults and counters.
// - Mode register resets to 000 hex, or 400 hex in clock variant.
// - Field parity high on odd field, always high when noninterlaced.
// - Equalization and serration appear only on composite frame sync.
// - Data registers are 12 bits; pulses use start and end counts.
// - Bit 0 picks separate or composite blank and line output content.
// - Bit 1 picks separate or composite sync and line-sync content.
// - Bit 2 swaps gates for cursor and frame interrupt.
// - Bits 4:3 choose interlaced, double or single serration; 10 illegal.
// - Double mode two pulses per line sync, single mode one.
// - Interlaced pulses occur in blanking of the first field only.
// - Bits 5 to 8 set output polarities, 1 active high.
// - Bit 9 set suppresses equalization and serration pulses.
// - Bit 10 runs the timing clock; clear stops timing generation.
// - Bit 11 enables counter test mode.
// - Registers 1 to 4: front porch, sync end, blank width, line length.
// - Line counter runs from 1 to the even line length.
// - Frame counter runs from 1 to the frame length in lines, or in half-lines when interlaced.
// - Composite sync and blank OR the active-high line and frame parts; in the equalization window composite sync uses the shaped pulses.
`timescale 1ns/100ps
`default_nettype none
module vsg_sync_gen #(
	parameter bit                     CLOCK_ON_AT_CLEAR = 1'b0,
	parameter logic [vsg_pkg::DW-1:0] FRAME_LINES       = 12'h20D,
	parameter logic [vsg_pkg::DW-1:0] V_FRONT           = 12'h007,
	parameter logic [vsg_pkg::DW-1:0] V_SYNC_END        = 12'h00D,
	parameter logic [vsg_pkg::DW-1:0] V_BLANK_W         = 12'h029,
	parameter logic [vsg_pkg::DW-1:0] EQ_END            = 12'h028,
	parameter logic [vsg_pkg::DW-1:0] SERR_END          = 12'h150,
	parameter logic [vsg_pkg::DW-1:0] EQ_V_START        = 12'h001,
	parameter logic [vsg_pkg::DW-1:0] EQ_V_END          = 12'h013,
	parameter logic [vsg_pkg::DW-1:0] HG_START          = 12'h0B0,
	parameter logic [vsg_pkg::DW-1:0] HG_END            = 12'h0C0,
	parameter logic [vsg_pkg::DW-1:0] VG_START          = 12'h040,
	parameter logic [vsg_pkg::DW-1:0] VG_END            = 12'h050,
	parameter logic [vsg_pkg::DW-1:0] VI_START          = 12'h002,
	parameter logic [vsg_pkg::DW-1:0] VI_END            = 12'h004
) (
	// Clock and resets
	input  wire logic       sys_clk,
	input  wire logic       reset_n,
	input  wire logic       async_init,
	// Load port
	input  wire logic [7:0] data_in,
	input  wire logic       addr_data_sel,
	input  wire logic       byte_half_select,
	input  wire logic       load_strobe,
	// Video outputs
	output logic            frame_blank_out,
	output logic            frame_sync_out,
	output logic            line_blank_or_gate_out,
	output logic            line_sync_or_gate_out,
	output logic            field_parity_out
);

	typedef struct packed {
		logic [vsg_pkg::NUM_REGS-1:0][vsg_pkg::DW-1:0] cfg;
		vsg_pkg::mode_t                              mode;
		logic [vsg_pkg::DW-1:0]                      hcnt;
		logic [vsg_pkg::CW-1:0]                      vcnt;
		logic                                        fb;
		logic                                        fs;
		logic                                        lb;
		logic                                        ls;
		logic                                        parity;
	} gen_t;

	gen_t                   st_r;
	gen_t                   st_nxt;
	logic [vsg_pkg::NUM_REGS-1:0][vsg_pkg::DW-1:0] shadow;
	logic [vsg_pkg::DW-1:0] mcr;
	logic [vsg_pkg::DW-1:0] line_len;
	logic [vsg_pkg::CW-1:0] hc;
	logic [vsg_pkg::CW-1:0] vlimit;
	logic                   run;
	logic                   interlaced;
	logic                   line_end;
	logic                   vstep;
	logic                   line_blanking;
	logic                   hsync;
	logic                   frame_blanking;
	logic                   vsync;
	logic                   eq_act;
	logic                   serr_act;
	logic                   eq_on;
	logic                   composite_syncing;
	logic                   composite_blanking;
	logic                   line_gating;
	logic                   frame_gating;
	logic                   cursor;
	logic                   frame_interrupt;

	// ------------------------------------------------------------------
	// Load port and pulse shaper
	// ------------------------------------------------------------------
	vsg_load_port #(
		.CLOCK_ON_AT_CLEAR (CLOCK_ON_AT_CLEAR)
	) u_port (
		.sys_clk          (sys_clk),
		.reset_n          (reset_n),
		.async_init       (async_init),
		.data_in          (data_in),
		.addr_data_sel    (addr_data_sel),
		.byte_half_select (byte_half_select),
		.load_strobe      (load_strobe),
		.shadow_regs      (shadow)
	);

	vsg_eq_shaper u_shaper (
		.hcnt        (st_r.hcnt),
		.line_len    (line_len),
		.front       (st_r.cfg[vsg_pkg::ADDR_FRONT]),
		.eq_end      (EQ_END),
		.serr_end    (SERR_END),
		.double_rate (st_r.mode != vsg_pkg::MD_NI_SINGLE),
		.eq_active   (eq_act),
		.serr_active (serr_act)
	);

	// ------------------------------------------------------------------
	// Timing signals from the current count
	// ------------------------------------------------------------------
	always_comb begin
		mcr = st_r.cfg[vsg_pkg::ADDR_MODE];
		line_len = st_r.cfg[vsg_pkg::ADDR_LINE_LEN];
		hc = {1'b0, st_r.hcnt};
		run = mcr[vsg_pkg::BIT_CLK_ON];
		interlaced = (st_r.mode == vsg_pkg::MD_INTERLACED);
		vlimit = interlaced ? {FRAME_LINES, 1'b0} : {1'b0, FRAME_LINES};
		line_blanking = vsg_pkg::in_window(hc, 13'h0001,
			{1'b0, st_r.cfg[vsg_pkg::ADDR_BLANK_W]});
		hsync = vsg_pkg::in_window(hc, {1'b0, st_r.cfg[vsg_pkg::ADDR_FRONT]},
			{1'b0, st_r.cfg[vsg_pkg::ADDR_SYNC_END]});
		frame_blanking = vsg_pkg::in_window(st_r.vcnt, 13'h0001, {1'b0, V_BLANK_W});
		vsync = vsg_pkg::in_window(st_r.vcnt, {1'b0, V_FRONT},
			{1'b0, V_SYNC_END});
		// Half-line counting in interlace puts the window in the first field only
		eq_on = !mcr[vsg_pkg::BIT_EQ_OFF] && vsg_pkg::in_window(st_r.vcnt,
			{1'b0, EQ_V_START}, {1'b0, EQ_V_END});
		composite_syncing = eq_on ? (vsync ? serr_act : eq_act) : (hsync | vsync);
		composite_blanking = line_blanking | frame_blanking;
		line_gating = vsg_pkg::in_window(hc, {1'b0, HG_START}, {1'b0, HG_END});
		frame_gating = vsg_pkg::in_window(st_r.vcnt, {1'b0, VG_START},
			{1'b0, VG_END});
		cursor = line_gating & frame_gating;
		frame_interrupt = vsg_pkg::in_window(st_r.vcnt, {1'b0, VI_START},
			{1'b0, VI_END});
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		line_end = 1'b0;
		vstep = 1'b0;
		// New values land only at a line boundary, never inside a line;
		// while the timing clock is stopped they land at once.
		if (!run || st_r.hcnt >= line_len)
			st_nxt.cfg = shadow;
		unique case (mcr[vsg_pkg::BIT_MODE_HI:vsg_pkg::BIT_MODE_LO])
			vsg_pkg::CODE_INTERLACED: st_nxt.mode = vsg_pkg::MD_INTERLACED;
			vsg_pkg::CODE_NI_DOUBLE: st_nxt.mode = vsg_pkg::MD_NI_DOUBLE;
			vsg_pkg::CODE_ILLEGAL: st_nxt.mode = st_r.mode;
			default: st_nxt.mode = vsg_pkg::MD_NI_SINGLE;
		endcase
		if (run) begin
			if (st_r.hcnt >= line_len) begin
				st_nxt.hcnt = 12'h001;
				line_end = 1'b1;
			end else begin
				st_nxt.hcnt = st_r.hcnt + 12'h001;
			end
			vstep = line_end || mcr[vsg_pkg::BIT_TEST] ||
				(interlaced && st_r.hcnt == (line_len >> 1));
			if (vstep)
				st_nxt.vcnt = (st_r.vcnt >= vlimit) ? 13'h0001 :
					st_r.vcnt + 13'h0001;
		end
		st_nxt.fb = vsg_pkg::apply_pol(mcr[vsg_pkg::BIT_BLANK_SEL] ?
			frame_blanking : composite_blanking, mcr[vsg_pkg::BIT_POL_BLANK]);
		st_nxt.fs = vsg_pkg::apply_pol(mcr[vsg_pkg::BIT_SYNC_SEL] ?
			vsync : composite_syncing, mcr[vsg_pkg::BIT_POL_SYNC]);
		st_nxt.lb = vsg_pkg::apply_pol(mcr[vsg_pkg::BIT_BLANK_SEL] ? line_blanking :
			(mcr[vsg_pkg::BIT_SPARE_SEL] ? cursor : line_gating),
			mcr[vsg_pkg::BIT_POL_LINE]);
		st_nxt.ls = vsg_pkg::apply_pol(mcr[vsg_pkg::BIT_SYNC_SEL] ? hsync :
			(mcr[vsg_pkg::BIT_SPARE_SEL] ? frame_interrupt : frame_gating),
			mcr[vsg_pkg::BIT_POL_LSYNC]);
		st_nxt.parity = !(interlaced && st_r.vcnt > {1'b0, FRAME_LINES});
		if (!reset_n) begin
			st_nxt = '0;
			st_nxt.cfg = vsg_pkg::reset_regs(CLOCK_ON_AT_CLEAR);
			st_nxt.vcnt = vsg_pkg::VCNT_RESET;
			st_nxt.fb = vsg_pkg::OUT_RESET;
			st_nxt.fs = vsg_pkg::OUT_RESET;
			st_nxt.lb = vsg_pkg::OUT_RESET;
			st_nxt.ls = vsg_pkg::OUT_RESET;
			st_nxt.parity = vsg_pkg::OUT_RESET;
		end
	end

	// ------------------------------------------------------------------
	// State register, on the falling edge of the pixel clock
	// ------------------------------------------------------------------
	always_ff @(negedge sys_clk or posedge async_init) begin
		if (async_init) begin
			st_r <= '0;
			st_r.cfg <= vsg_pkg::reset_regs(CLOCK_ON_AT_CLEAR);
			st_r.vcnt <= vsg_pkg::VCNT_RESET;
			st_r.fb <= vsg_pkg::OUT_RESET;
			st_r.fs <= vsg_pkg::OUT_RESET;
			st_r.lb <= vsg_pkg::OUT_RESET;
			st_r.ls <= vsg_pkg::OUT_RESET;
			st_r.parity <= vsg_pkg::OUT_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign frame_blank_out = st_r.fb;
	assign frame_sync_out = st_r.fs;
	assign line_blank_or_gate_out = st_r.lb;
	assign line_sync_or_gate_out = st_r.ls;
	assign field_parity_out = st_r.parity;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(negedge sys_clk); endclocking
	default disable iff (async_init || !reset_n);

	// Attempts begun on the release edge still see the reset state
	logic live;
	assign live = reset_n && !async_init;

	property p_hcnt_wrap;
		(run && st_r.hcnt >= line_len) |=> (st_r.hcnt == 12'h001);
	endproperty
	a_hcnt_wrap: assert property (p_hcnt_wrap)
		else $error("line counter did not restart at 1");

	property p_clock_stop;
		!run |=> $stable(st_r.hcnt) && $stable(st_r.vcnt);
	endproperty
	a_clock_stop: assert property (p_clock_stop)
		else $error("counters moved with timing clock stopped");

	property p_parity_high;
		!interlaced |=> field_parity_out;
	endproperty
	a_parity_high: assert property (p_parity_high)
		else $error("field parity low in noninterlaced mode");

	property p_illegal_hold;
		(mcr[4:3] == vsg_pkg::CODE_ILLEGAL) |=> (st_r.mode == $past(st_r.mode));
	endproperty
	a_illegal_hold: assert property (p_illegal_hold)
		else $error("illegal mode code changed the mode");

	property p_blank_sep;
		(live && mcr[0]) |=> (frame_blank_out ==
			($past(frame_blanking) ~^ $past(mcr[5])));
	endproperty
	a_blank_sep: assert property (p_blank_sep)
		else $error("separate frame blank wrong");

	property p_blank_comp;
		(live && !mcr[0]) |=> (frame_blank_out ==
			($past(line_blanking | frame_blanking) ~^ $past(mcr[5])));
	endproperty
	a_blank_comp: assert property (p_blank_comp)
		else $error("composite blank wrong");

	property p_sync_plain;
		(live && mcr[1]) |=> (frame_sync_out ==
			($past(vsync) ~^ $past(mcr[6])))
			&& (line_sync_or_gate_out == ($past(hsync) ~^ $past(mcr[8])));
	endproperty
	a_sync_plain: assert property (p_sync_plain)
		else $error("separate sync carries other pulses");

	property p_cursor_sel;
		(live && !mcr[0] && mcr[2]) |=> (line_blank_or_gate_out ==
			($past(line_gating & frame_gating) ~^ $past(mcr[7])));
	endproperty
	a_cursor_sel: assert property (p_cursor_sel)
		else $error("cursor pulse not on line output");

	property p_eq_off;
		(live && !mcr[1] && mcr[9]) |=> (frame_sync_out ==
			($past(hsync | vsync) ~^ $past(mcr[6])));
	endproperty
	a_eq_off: assert property (p_eq_off)
		else $error("suppressed pulses reached composite sync");

	c_line_wrap: cover property (run && line_end);
	c_even_field: cover property (interlaced && !st_r.parity);
	c_serration: cover property (eq_on && vsync && !mcr[1]);

endmodule // vsg_sync_gen
`default_nettype wire

// File: dv/vsg_host_model.sv
// Host model that programs the parallel load port of the sync generator
`timescale 1ns/100ps
`default_nettype none
module vsg_host_model (
	// Clock
	input  wire logic       sys_clk,
	// Load port
	output var  logic [7:0] data_in,
	output var  logic       addr_data_sel,
	output var  logic       byte_half_select,
	output var  logic       load_strobe
);
	initial begin
		data_in          = 8'h00;
		addr_data_sel    = 1'b0;
		byte_half_select = 1'b0;
		load_strobe      = 1'b1;
	end

	// ------------------------------------------------------------------
	// Strobe cycles
	// ------------------------------------------------------------------
	// Qualifiers lead the fall by a clock and hold well past the rise,
	// since the port only sees the strobe through its synchroniser
	task automatic load_cycle(input logic ads, input logic bhs,
		input logic [7:0] b);
		@(negedge sys_clk);
		addr_data_sel    <= ads;
		byte_half_select <= bhs;
		data_in          <= b;
		@(negedge sys_clk);
		load_strobe <= 1'b0;
		repeat (4) @(negedge sys_clk);
		load_strobe <= 1'b1;
		repeat (4) @(negedge sys_clk);
		data_in <= ~b;
	endtask

	task automatic write_reg(input logic [4:0] a, input logic [11:0] v);
		load_cycle(1'b0, 1'b0, {3'h0, a});
		load_cycle(1'b1, 1'b0, v[7:0]);
		load_cycle(1'b1, 1'b1, {4'h0, v[11:8]});
	endtask

	task automatic auto_write(input logic [4:0] a, input logic [11:0] v [4]);
		load_cycle(1'b0, 1'b1, {3'h0, a});
		foreach (v[i]) begin
			load_cycle(1'b1, 1'b0, v[i][7:0]);
			load_cycle(1'b1, 1'b1, {4'h0, v[i][11:8]});
		end
	endtask
endmodule // vsg_host_model
`default_nettype wire

// File: dv/tb.sv
// Self-checking testbench for the video sync generator
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ------------------------------------------------------------------
	// Signals and tables
	// ------------------------------------------------------------------
	logic       sys_clk, reset_n, async_init;
	logic [7:0] data_in;
	logic       addr_data_sel, byte_half_select, load_strobe;
	logic       frame_blank_out, frame_sync_out, field_parity_out;
	logic       line_blank_or_gate_out, line_sync_or_gate_out;
	int         err_count, n_tests;
	// Stopped at frame count 1: blank is active, the rest idle high
	localparam logic [15:0] IDLE [5] = '{16'h0000, 16'h0080, 16'h0080,
		16'h0080, 16'h0080};
	localparam logic [11:0] CFG [9] = '{12'h7EB, 12'h7E8, 12'h7EC, 12'h60B,
		12'h7FB, 12'h7E3, 12'h7F3, 12'h5E8, 12'h5F8};
	// Counts per frame of 768 clocks; FFFF means not judged
	localparam logic [15:0] EXP [9][5] = '{
		'{16'h0280, 16'h0060, 16'h00C0, 16'h0090, 16'h0300},
		'{16'h02A0, 16'h00DE, 16'h0060, 16'h0020, 16'h0300},
		'{16'h02A0, 16'h00DE, 16'h0004, 16'h0020, 16'h0300},
		'{16'h0080, 16'h02A0, 16'h0240, 16'h0270, 16'h0300},
		'{16'h0280, 16'h0060, 16'h00C0, 16'h0090, 16'h0300},
		'{16'h0140, 16'h0030, 16'h00C0, 16'h0090, 16'h0180},
		'{16'h0140, 16'h0030, 16'h00C0, 16'h0090, 16'h0180},
		'{16'h02A0, 16'h0132, 16'h0060, 16'h0020, 16'h0300},
		'{16'h02A0, 16'h0156, 16'h0060, 16'h0020, 16'h0300}};

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	vsg_host_model u_vsg_host_model (
		.sys_clk          (sys_clk),
		.data_in          (data_in),
		.addr_data_sel    (addr_data_sel),
		.byte_half_select (byte_half_select),
		.load_strobe      (load_strobe)
	);

	// Short frame of 48 lines; gating windows moved, other vertical windows keep their defaults
	vsg_sync_gen #(
		.FRAME_LINES (12'h030), .HG_START (12'h002), .HG_END (12'h004),
		.VG_START (12'h002), .VG_END (12'h004)
	) u_vsg_sync_gen (
		.sys_clk                (sys_clk),
		.reset_n                (reset_n),
		.async_init             (async_init),
		.data_in                (data_in),
		.addr_data_sel          (addr_data_sel),
		.byte_half_select       (byte_half_select),
		.load_strobe            (load_strobe),
		.frame_blank_out        (frame_blank_out),
		.frame_sync_out         (frame_sync_out),
		.line_blank_or_gate_out (line_blank_or_gate_out),
		.line_sync_or_gate_out  (line_sync_or_gate_out),
		.field_parity_out       (field_parity_out)
	);

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Counting high cycles over whole periods makes the window phase moot
	task automatic measure(input int n, input logic [15:0] e [5]);
		logic [15:0] c [5];
		c = '{default: 16'h0000};
		repeat (n) begin
			@(posedge sys_clk);
			c[0] = c[0] + {15'h0000, frame_blank_out};
			c[1] = c[1] + {15'h0000, frame_sync_out};
			c[2] = c[2] + {15'h0000, line_blank_or_gate_out};
			c[3] = c[3] + {15'h0000, line_sync_or_gate_out};
			c[4] = c[4] + {15'h0000, field_parity_out};
		end
		foreach (c[k])
			if (e[k] !== 16'hFFFF)
				check(c[k], e[k]);
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_clear;
		@(negedge sys_clk);
		async_init <= 1'b1;
		repeat (2) @(negedge sys_clk);
		@(posedge sys_clk);
		check({11'h000, frame_blank_out, frame_sync_out,
			line_blank_or_gate_out, line_sync_or_gate_out,
			field_parity_out}, 16'h001F);
		@(negedge sys_clk);
		async_init <= 1'b0;
		@(negedge sys_clk);
		measure(128, IDLE);
		$display("test clear done");
	endtask

	// Upper nibble set gives a 272 clock line
	task automatic t_manual;
		u_vsg_host_model.write_reg(5'h01, 12'h003);
		u_vsg_host_model.write_reg(5'h02, 12'h006);
		u_vsg_host_model.write_reg(5'h03, 12'h005);
		u_vsg_host_model.write_reg(5'h04, 12'h110);
		u_vsg_host_model.write_reg(5'h00, 12'h7EB);
		repeat (544) @(posedge sys_clk);
		measure(272, '{16'hFFFF, 16'hFFFF, 16'h0004, 16'h0003, 16'h0110});
		$display("test manual done");
	endtask

	// Rewritten while running; each written half lands at the next line boundary
	task automatic t_auto;
		u_vsg_host_model.auto_write(5'h01, '{12'h003, 12'h006, 12'h005,
			12'h010});
		repeat (600) @(posedge sys_clk);
		measure(768, EXP[0]);
		$display("test auto done");
	endtask

	task automatic t_modes;
		for (int r = 0; r < 9; r++) begin
			u_vsg_host_model.write_reg(5'h00, CFG[r]);
			repeat (256) @(posedge sys_clk);
			measure(768, EXP[r]);
		end
		$display("test modes done");
	endtask

	initial begin
		reset_n    = 1'b0;
		async_init = 1'b0;
		err_count  = 0;
		n_tests    = 0;
		repeat (12) @(negedge sys_clk);
		reset_n <= 1'b1;
		t_clear;
		t_manual;
		t_auto;
		t_modes;
		t_clear;
		print_verdict;
	end

	initial begin
		#1000000;
		$display("run limit reached");
		err_count++;
		print_verdict;
	end
endmodule // tb
`default_nettype wire
